//--- pcc_pwm_cycle_config.sv
// pwm cycle configuration register, overflow flag and compare steering
//
// Function
// - With the reload select bit set, compare byte accesses go to the reload bank, else to compare.
// - Reload bytes are copied into compare only for channels in 9, 10 or 11 bit pwm.
// - The interrupt request is raised while the overflow flag is set and its enable is set.
// - The overflow flag is set when the counter overflows out of the selected cycle length bit.
// - The overflow flag is set by hardware or a written 1 and is cleared only by software.
// - Bits 4 to 2 of the configuration register read zero and ignore writes.
// - The length select field sets one shared cycle: 00 is 8, 01 is 9, 11 is 11 bits.
// - A channel in 16-bit pwm ignores the length select and keeps a 16-bit cycle.
// - A channel's wide enable picks 16-bit pwm when set, 8 to 11 bit when clear.
`timescale 1ns/1ps
module pcc_pwm_cycle_config (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire pcc_pkg::pcc_sfr_req_t sfr_req_in,
    input wire logic [15:0] main_array_counter_in,
    input wire logic counter_tick_in,
    input wire logic [pcc_pkg::NUM_CH-1:0] pwm_mode_in,
    input wire logic [pcc_pkg::NUM_CH-1:0] wide_pwm_enable_in,
    output logic [7:0] sfr_rdata_out,
    output logic irq_out,
    output logic cycle_overflow_pulse_out,
    output logic [pcc_pkg::NUM_CH-1:0][4:0] channel_cycle_bits_out,
    output logic [pcc_pkg::NUM_CH-1:0][15:0] module_compare_value_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] cycle_mask(input logic [1:0] sel, input logic wide);
        logic [15:0] m;
        m = pcc_pkg::BASE_CYCLE_MASK;
        if (wide) begin
            m = pcc_pkg::WIDE_CYCLE_MASK;
        end else begin
            for (int b = 0; b < 3; b++) begin
                if (2'(b) < sel) begin
                    m[8 + b] = 1'b1;
                end
            end
        end
        return m;
    endfunction

    // returns {hit, channel, high byte}
    function automatic logic [3:0] cmp_decode(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        unique case (a)
            pcc_pkg::CMP_LOW_ADDR0: r = 4'h8;
            pcc_pkg::CMP_HIGH_ADDR0: r = 4'h9;
            pcc_pkg::CMP_LOW_ADDR1: r = 4'hA;
            pcc_pkg::CMP_HIGH_ADDR1: r = 4'hB;
            pcc_pkg::CMP_LOW_ADDR2: r = 4'hC;
            pcc_pkg::CMP_HIGH_ADDR2: r = 4'hD;
            default: r = 4'h0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // configuration register and overflow detect
    // ------------------------------------------------------------
    pcc_pkg::pcc_cfg_t cfg;
    pcc_pkg::pcc_cfg_t next_cfg;
    logic cfg_wr;
    logic cfg_rd;
    logic overflow_hit;
    logic next_irq;
    logic [15:0] shared_mask;
    logic [3:0] wr_dec;
    logic [3:0] rd_dec;
    logic cmp_rd;
    logic [7:0] cfg_rd_data;
    logic [7:0] next_rdata;
    logic [pcc_pkg::NUM_CH-1:0] reload_load;
    logic [pcc_pkg::NUM_CH-1:0][4:0] next_cycle_bits;
    pcc_pkg::pcc_bank_idx_t wr_idx;
    pcc_pkg::pcc_bank_idx_t rd_idx;

    always_comb begin
        cfg_wr = sfr_req_in.wr && (sfr_req_in.addr == pcc_pkg::PWM_CFG_ADDR);
        cfg_rd = sfr_req_in.rd && (sfr_req_in.addr == pcc_pkg::PWM_CFG_ADDR);
        shared_mask = cycle_mask(cfg.cycle_length_select, 1'b0);
        // wrap of the selected low bits
        overflow_hit = counter_tick_in && ((main_array_counter_in & shared_mask) == shared_mask);
        next_cfg = cfg;
        if (cfg_wr) begin
            next_cfg.reload_bank_select = sfr_req_in.wdata[pcc_pkg::RELOAD_SEL_BIT];
            next_cfg.cycle_overflow_irq_enable = sfr_req_in.wdata[pcc_pkg::IRQ_EN_BIT];
            next_cfg.cycle_overflow_flag = sfr_req_in.wdata[pcc_pkg::OVF_BIT];
            next_cfg.cycle_length_select = sfr_req_in.wdata[pcc_pkg::LEN_MSB:pcc_pkg::LEN_LSB];
        end
        // hardware set wins over a software clear in the same cycle
        if (overflow_hit) begin
            next_cfg.cycle_overflow_flag = 1'b1;
        end
        next_irq = next_cfg.cycle_overflow_flag && next_cfg.cycle_overflow_irq_enable;
        cfg_rd_data = 8'h00;
        cfg_rd_data[pcc_pkg::RELOAD_SEL_BIT] = cfg.reload_bank_select;
        cfg_rd_data[pcc_pkg::IRQ_EN_BIT] = cfg.cycle_overflow_irq_enable;
        cfg_rd_data[pcc_pkg::OVF_BIT] = cfg.cycle_overflow_flag;
        cfg_rd_data[pcc_pkg::LEN_MSB:pcc_pkg::LEN_LSB] = cfg.cycle_length_select;
        for (int c = 0; c < pcc_pkg::NUM_CH; c++) begin
            // wide channels keep 16 bits, chosen by wide enable
            if (wide_pwm_enable_in[c]) begin
                next_cycle_bits[c] = pcc_pkg::WIDE_CYCLE_BITS;
            end else begin
                next_cycle_bits[c] = pcc_pkg::BASE_CYCLE_BITS + {3'h0, cfg.cycle_length_select};
            end
            // reload only for 9 to 11 bit pwm
            reload_load[c] = overflow_hit && pwm_mode_in[c] && !wide_pwm_enable_in[c]
                && (cfg.cycle_length_select != 2'h0);
        end
    end

    // ------------------------------------------------------------
    // compare steering
    // ------------------------------------------------------------
    always_comb begin
        wr_dec = cmp_decode(sfr_req_in.addr);
        rd_dec = wr_dec;
        wr_idx = {cfg.reload_bank_select, wr_dec[2:1], wr_dec[0]};
        rd_idx = {cfg.reload_bank_select, rd_dec[2:1], rd_dec[0]};
        cmp_rd = sfr_req_in.rd && rd_dec[3];
    end

    // register reads also leave through the bank's read flop
    pcc_cap_bank u_bank (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_en_in(sfr_req_in.wr && wr_dec[3]),
        .wr_idx_in(wr_idx),
        .wr_data_in(sfr_req_in.wdata),
        .rd_idx_in(rd_idx),
        .reload_load_in(reload_load),
        .rd_bank_in(cmp_rd),
        .rd_other_in(next_rdata),
        .rd_data_out(sfr_rdata_out),
        .module_compare_value_out(module_compare_value_out)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = cfg_rd ? cfg_rd_data : 8'h00;
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cfg <= pcc_pkg::pcc_cfg_t'(5'h00);
            irq_out <= 1'b0;
            cycle_overflow_pulse_out <= 1'b0;
            channel_cycle_bits_out <= '0;
        end else begin
            cfg <= next_cfg;
            irq_out <= next_irq;
            cycle_overflow_pulse_out <= overflow_hit;
            channel_cycle_bits_out <= next_cycle_bits;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    a_ovf_sets_flag: assert property (overflow_hit |=> cfg.cycle_overflow_flag)
        else $error("overflow did not set flag");
    a_pulse_hit: assert property (overflow_hit |=> cycle_overflow_pulse_out)
        else $error("overflow pulse missing");
    a_no_pulse: assert property (!overflow_hit |=> !cycle_overflow_pulse_out)
        else $error("overflow pulse without a hit");
    a_flag_sticky: assert property (cfg.cycle_overflow_flag && !cfg_wr |=>
            cfg.cycle_overflow_flag)
        else $error("flag cleared without software");
    a_sw_set_flag: assert property (cfg_wr && sfr_req_in.wdata[pcc_pkg::OVF_BIT] |=>
            cfg.cycle_overflow_flag)
        else $error("software write of one did not set flag");
    a_irq_follows: assert property (irq_out ==
            (cfg.cycle_overflow_flag && cfg.cycle_overflow_irq_enable))
        else $error("interrupt does not match flag and enable");
    a_irq_masked: assert property (!cfg.cycle_overflow_irq_enable |-> !irq_out)
        else $error("interrupt raised while masked");
    a_unused_zero: assert property (cfg_rd |=> sfr_rdata_out[4:2] == 3'h0)
        else $error("unused bits read nonzero");
    a_len_bits: assert property (!wide_pwm_enable_in[0] |=>
            channel_cycle_bits_out[0] == 5'h08 + {3'h0, $past(cfg.cycle_length_select)})
        else $error("cycle length wrong");
    a_len_bits_ch1: assert property (!wide_pwm_enable_in[1] |=>
            channel_cycle_bits_out[1] == 5'h08 + {3'h0, $past(cfg.cycle_length_select)})
        else $error("cycle length wrong on channel one");
    a_len_8: assert property (cfg.cycle_length_select == 2'h0 |-> shared_mask == 16'h00FF)
        else $error("code zero not eight bits");
    a_len_11: assert property (cfg.cycle_length_select == 2'h3 |-> shared_mask == 16'h07FF)
        else $error("code three not eleven bits");
    a_wide_cycle: assert property (wide_pwm_enable_in[2] |=> channel_cycle_bits_out[2] == 5'h10)
        else $error("wide channel not sixteen bits");
    a_no_reload_8: assert property (cfg.cycle_length_select == 2'h0 |-> reload_load == '0)
        else $error("reload in eight bit mode");
    a_reload_steer: assert property (sfr_req_in.wr && wr_dec[3]
            && cfg.reload_bank_select && reload_load == '0
            |=> $stable(module_compare_value_out))
        else $error("reload bank write reached a compare register");
    a_cmp_write: assert property (sfr_req_in.wr && wr_dec == 4'hB
            && !cfg.reload_bank_select
            |=> module_compare_value_out[1][15:8] == $past(sfr_req_in.wdata))
        else $error("compare write did not land");
    a_cmp_read: assert property (sfr_req_in.rd && rd_dec == 4'h8
            && !cfg.reload_bank_select
            |=> sfr_rdata_out == $past(module_compare_value_out[0][7:0]))
        else $error("compare read returned the wrong byte");
    a_ten_bit: assert property (cfg.cycle_length_select == 2'h2 |-> shared_mask == 16'h03FF)
        else $error("code ten not ten bits");

    // ------------------------------------------------------------
    // covers
    // ------------------------------------------------------------
    c_overflow: cover property (overflow_hit);
    c_irq: cover property (!irq_out ##1 irq_out);
    c_reload: cover property (|reload_load);
    c_set_and_clear: cover property (overflow_hit && cfg_wr && !sfr_req_in.wdata[5]);
    c_reload_read: cover property (cmp_rd && cfg.reload_bank_select);
endmodule

//--- pcc_pkg.sv
// shared constants and types of the pwm cycle configuration block
package pcc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] PWM_CFG_ADDR = 8'hF7;
    localparam logic [7:0] PWM_CFG_RESET = 8'h00;
    localparam logic [7:0] PWM_CFG_WMASK = 8'hE3;
    localparam int RELOAD_SEL_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int OVF_BIT = 5;
    localparam int LEN_MSB = 1;
    localparam int LEN_LSB = 0;
    localparam int NUM_CH = 3;
    // compare byte addresses, channel 0 to 2
    localparam logic [7:0] CMP_LOW_ADDR0 = 8'hE9;
    localparam logic [7:0] CMP_HIGH_ADDR0 = 8'hFA;
    localparam logic [7:0] CMP_LOW_ADDR1 = 8'hEB;
    localparam logic [7:0] CMP_HIGH_ADDR1 = 8'hEC;
    localparam logic [7:0] CMP_LOW_ADDR2 = 8'hED;
    localparam logic [7:0] CMP_HIGH_ADDR2 = 8'hEE;
    localparam logic [4:0] BASE_CYCLE_BITS = 5'h08;
    localparam logic [4:0] WIDE_CYCLE_BITS = 5'h10;
    localparam logic [15:0] WIDE_CYCLE_MASK = 16'hFFFF;
    localparam logic [15:0] BASE_CYCLE_MASK = 16'h00FF;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } pcc_sfr_req_t;

    typedef struct packed {
        logic reload_bank_select;
        logic cycle_overflow_irq_enable;
        logic cycle_overflow_flag;
        logic [1:0] cycle_length_select;
    } pcc_cfg_t;

    // index into the compare bank: {reload bank, channel, high byte}
    typedef struct packed {
        logic bank;
        logic [1:0] ch;
        logic hi;
    } pcc_bank_idx_t;
endpackage

//--- pcc_cap_bank.sv
// compare and auto-reload byte store for three channels
`timescale 1ns/1ps
module pcc_cap_bank (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic wr_en_in,
    input wire pcc_pkg::pcc_bank_idx_t wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire pcc_pkg::pcc_bank_idx_t rd_idx_in,
    input wire logic [pcc_pkg::NUM_CH-1:0] reload_load_in,
    input wire logic rd_bank_in,
    input wire logic [7:0] rd_other_in,
    output logic [7:0] rd_data_out,
    output logic [pcc_pkg::NUM_CH-1:0][15:0] module_compare_value_out
);
    logic [7:0] mem [16];
    logic [7:0] next_mem [16];
    logic [7:0] next_rd_data;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            next_mem[i] = mem[i];
        end
        // reload copies into compare bytes first so a same-cycle cpu write wins
        for (int c = 0; c < pcc_pkg::NUM_CH; c++) begin
            if (reload_load_in[c]) begin
                next_mem[{1'b0, 2'(c), 1'b0}] = mem[{1'b1, 2'(c), 1'b0}];
                next_mem[{1'b0, 2'(c), 1'b1}] = mem[{1'b1, 2'(c), 1'b1}];
            end
        end
        if (wr_en_in) begin
            next_mem[wr_idx_in] = wr_data_in;
        end
        // one output flop serves every read source, so the bus sees no mux after a flop
        next_rd_data = rd_bank_in ? mem[rd_idx_in] : rd_other_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 8'h00;
            end
            rd_data_out <= 8'h00;
        end else begin
            mem <= next_mem;
            rd_data_out <= next_rd_data;
        end
    end

    always_comb begin
        for (int c = 0; c < pcc_pkg::NUM_CH; c++) begin
            module_compare_value_out[c] = {mem[{1'b0, 2'(c), 1'b1}], mem[{1'b0, 2'(c), 1'b0}]};
        end
    end
endmodule

//--- pcc_pwm_cycle_config_tb_top.sv
// self-checking testbench of the pwm cycle configuration block
`timescale 1ns/1ps
module pcc_pwm_cycle_config_tb_top;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    pcc_pkg::pcc_sfr_req_t sfr_req_in = '0;
    logic [15:0] main_array_counter_in = 16'h0000;
    logic counter_tick_in = 1'b0;
    logic [pcc_pkg::NUM_CH-1:0] pwm_mode_in = 3'h5;
    logic [pcc_pkg::NUM_CH-1:0] wide_pwm_enable_in = 3'h4;
    logic [7:0] sfr_rdata_out;
    logic irq_out;
    logic cycle_overflow_pulse_out;
    logic [pcc_pkg::NUM_CH-1:0][4:0] channel_cycle_bits_out;
    logic [pcc_pkg::NUM_CH-1:0][15:0] module_compare_value_out;
    int miscompares = 0;
    int comparisons = 0;

    always #4 core_clk_in = ~core_clk_in;

    pcc_pwm_cycle_config dut_u (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .sfr_req_in(sfr_req_in),
        .main_array_counter_in(main_array_counter_in),
        .counter_tick_in(counter_tick_in),
        .pwm_mode_in(pwm_mode_in),
        .wide_pwm_enable_in(wide_pwm_enable_in),
        .sfr_rdata_out(sfr_rdata_out),
        .irq_out(irq_out),
        .cycle_overflow_pulse_out(cycle_overflow_pulse_out),
        .channel_cycle_bits_out(channel_cycle_bits_out),
        .module_compare_value_out(module_compare_value_out)
    );

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        comparisons++;
        if (seen !== expected) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen 0x%0h expected 0x%0h", $time, seen, expected);
        end
    endtask

    // every access leaves one idle cycle first, so strobes never toggle twice in a step
    task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk_in);
        #1;
        sfr_req_in.addr = addr;
        sfr_req_in.wdata = data;
        sfr_req_in.wr = 1'b1;
        @(posedge core_clk_in);
        #1;
        sfr_req_in.wr = 1'b0;
    endtask

    // read data stands only in the cycle after the taken edge
    task automatic sfr_rd(input logic [7:0] addr, input logic [7:0] expected);
        @(posedge core_clk_in);
        #1;
        sfr_req_in.addr = addr;
        sfr_req_in.rd = 1'b1;
        @(posedge core_clk_in);
        #1;
        sfr_req_in.rd = 1'b0;
        check(16'(sfr_rdata_out), 16'(expected));
    endtask

    task automatic tick(input logic [15:0] count);
        @(posedge core_clk_in);
        #1;
        main_array_counter_in = count;
        counter_tick_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        counter_tick_in = 1'b0;
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_in);
        #1;
        reset_n_in = 1'b1;
        sfr_rd(pcc_pkg::PWM_CFG_ADDR, pcc_pkg::PWM_CFG_RESET);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'hFF);
        check(16'(irq_out), 16'h0001);
        sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'hE3);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h00);
        sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'h00);
        // a count one bit short must not hit, the full length must
        for (int s = 0; s < 4; s++) begin
            sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'(s));
            tick(16'((1 << (7 + s)) - 1));
            check(16'(cycle_overflow_pulse_out), 16'h0000);
            sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'(s));
            check(16'(channel_cycle_bits_out[0]), 16'(8 + s));
            check(16'(channel_cycle_bits_out[1]), 16'(8 + s));
            check(16'(channel_cycle_bits_out[2]), 16'h0010);
            tick(16'((1 << (8 + s)) - 1));
            check(16'(cycle_overflow_pulse_out), 16'h0001);
            repeat (3) @(posedge core_clk_in);
            sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'(8'h20 | s));
            sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'(s));
            sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'(s));
        end
        // interrupt masking, software and hardware set
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h20);
        check(16'(irq_out), 16'h0000);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h60);
        check(16'(irq_out), 16'h0001);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h40);
        check(16'(irq_out), 16'h0000);
        tick(16'h00FF);
        check(16'(irq_out), 16'h0001);
        // reload bank: 8-bit hit must not copy, 9-bit hit copies eligible channels only
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h80);
        sfr_wr(pcc_pkg::CMP_LOW_ADDR0, 8'h34);
        sfr_wr(pcc_pkg::CMP_HIGH_ADDR0, 8'h12);
        sfr_wr(pcc_pkg::CMP_LOW_ADDR1, 8'h55);
        sfr_wr(pcc_pkg::CMP_LOW_ADDR2, 8'hAB);
        sfr_wr(pcc_pkg::CMP_HIGH_ADDR2, 8'hCD);
        sfr_rd(pcc_pkg::CMP_HIGH_ADDR0, 8'h12);
        sfr_rd(pcc_pkg::CMP_LOW_ADDR2, 8'hAB);
        check(module_compare_value_out[0], 16'h0000);
        tick(16'h00FF);
        check(module_compare_value_out[0], 16'h0000);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h81);
        tick(16'h01FF);
        check(module_compare_value_out[0], 16'h1234);
        check(module_compare_value_out[1], 16'h0000);
        check(module_compare_value_out[2], 16'h0000);
        sfr_wr(pcc_pkg::PWM_CFG_ADDR, 8'h01);
        sfr_rd(pcc_pkg::CMP_LOW_ADDR0, 8'h34);
        sfr_rd(pcc_pkg::CMP_LOW_ADDR2, 8'h00);
        sfr_wr(pcc_pkg::CMP_HIGH_ADDR1, 8'h77);
        check(module_compare_value_out[1], 16'h7700);
        sfr_rd(8'h00, 8'h00);
        // a software clear in the cycle of a hit must lose to the hit
        @(posedge core_clk_in);
        #1;
        sfr_req_in.addr = pcc_pkg::PWM_CFG_ADDR;
        sfr_req_in.wdata = 8'h00;
        sfr_req_in.wr = 1'b1;
        main_array_counter_in = 16'h01FF;
        counter_tick_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        sfr_req_in.wr = 1'b0;
        counter_tick_in = 1'b0;
        check(16'(cycle_overflow_pulse_out), 16'h0001);
        sfr_rd(pcc_pkg::PWM_CFG_ADDR, 8'h20);
        // reset in mid-run clears the register and the banks
        @(posedge core_clk_in);
        #1;
        reset_n_in = 1'b0;
        repeat (2) @(posedge core_clk_in);
        #1;
        reset_n_in = 1'b1;
        check(module_compare_value_out[0], 16'h0000);
        sfr_rd(pcc_pkg::PWM_CFG_ADDR, pcc_pkg::PWM_CFG_RESET);
        summarize();
    end

    // tests take about 130 cycles; this limit is far beyond that
    initial begin
        repeat (3000) @(posedge core_clk_in);
        miscompares++;
        summarize();
    end
endmodule
